// ### hw/ptg_trigger_gen.sv
// PWM ADC trigger generator with Avalon-MM register slave
`timescale 1ns/1ps
`include "ptg_cfg.svh"

// Overview
// Two compare paths, primary and secondary, watch the local time base.
// A match counts once per count value, so a stalled count cannot retrigger.
// Dual-cycle phase codes pick the up or down half of each period.
// Compares at zero or at the period are seen once per dual cycle anyway.
// Each path has its own divider counter; both read one divider field.
// The merge bit folds secondary pulses into the ADC trigger.
// The source bit picks which fired path raises the interrupt event.
// Status bits are sticky and clear on the read that returns them.
// Trigger outputs are registered: one cycle late, one cycle wide.
// Register bus: every access costs exactly two cycles.
// Writes land on the first edge, while waitrequest is still high.
// Read data are captured on that edge too and stand until the next read.
// Phase, merge and source bits are frozen while the module is enabled.
// Limitation: the divider field is shared, so both paths divide alike.
// Limitation: a count that repeats the same value is not a new match.
// Trade-off: the match compare is combinational from the time base,
// which keeps latency at one cycle but puts it on the input timing path.
// Time-base inputs come from this clock domain and are not synchronised.

module ptg_trigger_gen
    import ptg_pkg::*;
#(
    // Compare width follows the time-base count width
    parameter int CMP_W = 16,
    // Divider counter width follows the divider field
    parameter int DIV_W = 4
)
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire ptg_tbase_t tbase,
    input wire logic module_enable,
    output ptg_trig_t trig,
    output logic irq
);

    // Widths that the register layout cannot hold are refused
    if (CMP_W != 16)
    begin : g_bad_cmp_w
        $error("compare width must equal the time-base count width");
    end
    if (DIV_W != (`PTG_DIV_HI - `PTG_DIV_LO + 1))
    begin : g_bad_div_w
        $error("divider width must equal the divider field width");
    end

    // Compare values and control fields
    logic [CMP_W-1:0] pri_cmp_q;
    logic [CMP_W-1:0] sec_cmp_q;
    ptg_ctrl_t ctrl_q;
    logic trig_irq_en_q;

    // Interrupt status and mask, one layout
    logic [`PTG_STAT_W-1:0] status_q;
    logic [`PTG_STAT_W-1:0] mask_q;

    // Time-base history
    logic [15:0] prev_count_q;
    logic tb_valid_q;

    // Bus state and registered read data
    ptg_bus_t bus_q;
    ptg_bus_t bus_d;
    logic [31:0] rdata_q;

    // Output pulses and interrupt level
    ptg_trig_t trig_q;
    logic irq_q;

    // Byte-enable write merge for compare and control writes; lanes left low keep their old bits
    wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                           {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // Request state; a request is taken only in the idle cycle
    wire acc_done = (bus_q == PTG_BUS_DONE);
    wire wr_go = avs_write && !acc_done;
    wire rd_go = avs_read && !acc_done;

    // Register address decode
    wire at_pri = (avs_address == `PTG_ADDR_PRI_CMP);
    wire at_ctrl = (avs_address == `PTG_ADDR_CTRL);
    wire at_sec = (avs_address == `PTG_ADDR_SEC_CMP);
    wire at_status = (avs_address == `PTG_ADDR_STATUS);
    wire at_mask = (avs_address == `PTG_ADDR_MASK);
    wire at_chan = (avs_address == `PTG_ADDR_CHAN);

    // Write strobes, one per register except status, each lasting one cycle
    wire wr_pri = wr_go && at_pri;
    wire wr_ctrl = wr_go && at_ctrl;
    wire wr_sec = wr_go && at_sec;
    wire wr_mask = wr_go && at_mask;
    wire wr_chan = wr_go && at_chan;
    // Status is cleared by the read that returns it
    wire rd_status = rd_go && at_status;

    // Current control word, unused bits zero
    wire [31:0] ctrl_word = {16'h0000, ctrl_q.div, ctrl_q.pri_phase, ctrl_q.sec_phase,
                             ctrl_q.merge, ctrl_q.irq_src, 6'h00};
    // Merged new words
    wire [31:0] ctrl_new = ((ctrl_word & ~be_mask) | (avs_writedata & be_mask))
                           & `PTG_CTRL_MASK;
    wire [31:0] pri_new = (({16'h0000, pri_cmp_q} & ~be_mask) | (avs_writedata & be_mask));
    wire [31:0] sec_new = (({16'h0000, sec_cmp_q} & ~be_mask) | (avs_writedata & be_mask));
    // Only the lane that holds the enable bit may change it
    wire chan_word_ien = avs_byteenable[2] ? avs_writedata[`PTG_CHAN_IEN_BIT]
                                           : trig_irq_en_q;

    // Phase, merge and source bits freeze while the module runs, so a
    // late write cannot split one PWM period between two modes
    wire [31:0] ctrl_keep = {ctrl_new[31:`PTG_PSEL_HI+1],
                             ctrl_word[`PTG_PSEL_HI:`PTG_ISRC_BIT],
                             ctrl_new[`PTG_ISRC_BIT-1:0]};
    wire [31:0] ctrl_wr = module_enable ? ctrl_keep : ctrl_new;

    // Read mux, unmapped addresses read zero
    logic [31:0] rd_mux;
    always_comb
    begin
        case (avs_address)
            `PTG_ADDR_PRI_CMP: rd_mux = {16'h0000, pri_cmp_q};
            `PTG_ADDR_CTRL: rd_mux = ctrl_word;
            `PTG_ADDR_SEC_CMP: rd_mux = {16'h0000, sec_cmp_q};
            `PTG_ADDR_STATUS: rd_mux = {29'h0, status_q};
            `PTG_ADDR_MASK: rd_mux = {29'h0, mask_q};
            `PTG_ADDR_CHAN: rd_mux = {10'h000, trig_irq_en_q, 21'h000000};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // Time-base match detection; a count change qualifies each match once,
    // so a time base that holds its value does not fire every cycle
    wire tb_moved = !tb_valid_q || (tbase.count != prev_count_q);

    // Phase filters; codes 00 and 11 pass all, single-cycle ignores phase
    function automatic logic phase_ok(input logic [1:0] sel, input logic dir,
                                      input logic dual, input logic edge_pt);
        logic ok;
        ok = 1'b1;
        if (dual && !edge_pt)
        begin
            if (sel == `PTG_PHASE_UP)
                ok = !dir;
            else if (sel == `PTG_PHASE_DOWN)
                ok = dir;
        end
        return ok;
    endfunction : phase_ok

    // Per-path operands, index 0 primary and 1 secondary
    wire [CMP_W-1:0] cmp_v [0:1];
    wire [1:0] sel_v [0:1];
    wire [1:0] hit_v;
    wire [1:0] edge_v;
    wire [1:0] raw_v;
    wire [1:0] fire_v;
    assign cmp_v[0] = pri_cmp_q;
    assign cmp_v[1] = sec_cmp_q;
    assign sel_v[0] = ctrl_q.pri_phase;
    assign sel_v[1] = ctrl_q.sec_phase;

    // One compare, phase filter and divider per path
    for (genvar i = 0; i < 2; i++)
    begin : g_path
        logic [DIV_W-1:0] cnt_q;
        // Zero compare fires at rollover, which is the count reaching zero
        assign hit_v[i] = tb_moved && (tbase.count == cmp_v[i]);
        // At zero or period the turnaround is seen once per dual cycle
        assign edge_v[i] = (cmp_v[i] == 16'h0000) || (cmp_v[i] == tbase.period);
        assign raw_v[i] = hit_v[i] && phase_ok(sel_v[i], tbase.dir, tbase.dual_cycle,
                                               edge_v[i]);
        // Fires when the count reaches the shared divider field
        assign fire_v[i] = raw_v[i] && (cnt_q >= ctrl_q.div);

        // Restart after each output, so the spacing is exactly
        // the divider field plus one raw events
        always_ff @(posedge clock)
        begin
            if (!nrst)
                cnt_q <= '0;
            else if (fire_v[i])
                cnt_q <= '0;
            else if (raw_v[i])
                cnt_q <= cnt_q + 1'b1;
        end
    end : g_path

    // Named views of the two paths
    wire pri_fire = fire_v[0];
    wire sec_fire = fire_v[1];

    // Interrupt source selection
    wire irq_event = trig_irq_en_q && (ctrl_q.irq_src ? sec_fire
                     : (pri_fire || (ctrl_q.merge && sec_fire)));
    wire [`PTG_STAT_W-1:0] stat_set = {sec_fire, pri_fire, irq_event};
    // Next status; a new event wins over the clear-on-read
    wire [`PTG_STAT_W-1:0] status_d = (rd_status ? '0 : status_q) | stat_set;

    // Bus handshake: one wait cycle, answer on the second edge
    always_comb
    begin
        case (bus_q)
            PTG_BUS_IDLE: bus_d = (avs_read || avs_write) ? PTG_BUS_DONE : PTG_BUS_IDLE;
            PTG_BUS_DONE: bus_d = PTG_BUS_IDLE;
            default: bus_d = PTG_BUS_IDLE;
        endcase
    end

    // Done lasts one cycle, so even back-to-back
    // requests each pay their one wait cycle
    always_ff @(posedge clock)
    begin
        if (!nrst)
            bus_q <= PTG_BUS_IDLE;
        else
            bus_q <= bus_d;
    end

    // Read data captured while waitrequest is high
    always_ff @(posedge clock)
    begin
        if (!nrst)
            rdata_q <= 32'h00000000;
        else if (rd_go)
            rdata_q <= rd_mux;
    end

    // Primary compare value
    always_ff @(posedge clock)
    begin
        if (!nrst)
            pri_cmp_q <= '0;
        else if (wr_pri)
            pri_cmp_q <= pri_new[CMP_W-1:0];
    end

    // Secondary compare value
    always_ff @(posedge clock)
    begin
        if (!nrst)
            sec_cmp_q <= '0;
        else if (wr_sec)
            sec_cmp_q <= sec_new[CMP_W-1:0];
    end

    // Trigger control; frozen fields were merged in above
    always_ff @(posedge clock)
    begin
        if (!nrst)
            ctrl_q <= '0;
        else if (wr_ctrl)
            ctrl_q <= ptg_ctrl_t'(ctrl_wr[`PTG_DIV_HI:`PTG_ISRC_BIT]);
    end

    // Channel copy of the trigger interrupt enable
    always_ff @(posedge clock)
    begin
        if (!nrst)
            trig_irq_en_q <= 1'b0;
        else if (wr_chan)
            trig_irq_en_q <= chan_word_ien;
    end

    // Interrupt mask
    always_ff @(posedge clock)
    begin
        if (!nrst)
            mask_q <= '0;
        else if (wr_mask)
            mask_q <= avs_writedata[`PTG_STAT_W-1:0];
    end

    // Sticky status
    always_ff @(posedge clock)
    begin
        if (!nrst)
            status_q <= '0;
        else
            status_q <= status_d;
    end

    // Last count seen, for single match per count value
    always_ff @(posedge clock)
    begin
        if (!nrst)
            prev_count_q <= 16'h0000;
        else
            prev_count_q <= tbase.count;
    end

    // History valid; the first cycle after reset counts as moved
    always_ff @(posedge clock)
    begin
        if (!nrst)
            tb_valid_q <= 1'b0;
        else
            tb_valid_q <= 1'b1;
    end

    // Registered one-cycle trigger pulses
    always_ff @(posedge clock)
    begin
        if (!nrst)
            trig_q <= '0;
        else
        begin
            trig_q.pri <= pri_fire;
            trig_q.sec <= sec_fire;
            trig_q.adc <= pri_fire || (ctrl_q.merge && sec_fire);
        end
    end

    // Level interrupt from the status about to be stored, so it
    // rises with the trigger pulse and falls with the clearing read
    always_ff @(posedge clock)
    begin
        if (!nrst)
            irq_q <= 1'b0;
        else
            irq_q <= |(status_d & mask_q);
    end

    // Port drivers
    assign avs_waitrequest = (avs_read || avs_write) && !acc_done;
    assign avs_readdata = rdata_q;
    assign trig = trig_q;
    assign irq = irq_q;

endmodule : ptg_trigger_gen

// ### hw/ptg_cfg.svh
// Constants for the PWM ADC trigger generator
// Operation
// - Primary 16-bit compare matching local time base gives raw primary trigger.
// - Primary trigger interrupts only when trigger_irq_enable is set; the code's primary status bit still drives irq through mask bit 1 without it.
// - Compare value zero triggers at the PWM period boundary.
// - Divider passes one event in (field plus one); 0000 every, 1111 sixteenth.
// - Every raw primary event goes through divider; phase ignored in single-cycle.
// - Primary phase 10 in dual-cycle counts only up-counting matches.
// - Primary phase 01 in dual-cycle counts only down-counting matches.
// - Primary phase 00 counts every match; two per dual-cycle period.
// - Reserved primary phase 11 behaves like 00.
// - Dual-cycle compare of zero or period gives one interrupt per cycle.
// - Secondary phase selects halves like primary; 00 and 11 count all.
// - Secondary raw events use their own separate divider; the code shares the primary divider field.
// - Dual trigger merge set ORs secondary into primary ADC trigger.
// - Secondary triggers are produced whatever the merge bit says.
// - Irq source bit picks secondary; else primary, or OR when merging.
// - Secondary 16-bit compare triggers ADC; interrupts with enable and merge.
`ifndef PTG_CFG_SVH
`define PTG_CFG_SVH

`define PTG_ADDR_PRI_CMP 4'h0
`define PTG_ADDR_CTRL 4'h1
`define PTG_ADDR_SEC_CMP 4'h2
`define PTG_ADDR_STATUS 4'h3
`define PTG_ADDR_MASK 4'h4
`define PTG_ADDR_CHAN 4'h5

`define PTG_DIV_HI 15
`define PTG_DIV_LO 12
`define PTG_PSEL_HI 11
`define PTG_PSEL_LO 10
`define PTG_SSEL_HI 9
`define PTG_SSEL_LO 8
`define PTG_MERGE_BIT 7
`define PTG_ISRC_BIT 6
`define PTG_CTRL_MASK 32'h0000ffc0
`define PTG_CMP_MASK 32'h0000ffff
`define PTG_CHAN_IEN_BIT 21
`define PTG_CHAN_DUAL_BIT 0

`define PTG_PHASE_UP 2'h2
`define PTG_PHASE_DOWN 2'h1

`define PTG_STAT_IRQ 0
`define PTG_STAT_PRI 1
`define PTG_STAT_SEC 2
`define PTG_STAT_W 3

`endif

// ### hw/ptg_pkg.sv
// Types for the PWM ADC trigger generator
package ptg_pkg;
    typedef struct packed {
        logic [3:0] div;
        logic [1:0] pri_phase;
        logic [1:0] sec_phase;
        logic merge;
        logic irq_src;
    } ptg_ctrl_t;

    typedef struct packed {
        logic [15:0] count;
        logic [15:0] period;
        logic dir;
        logic dual_cycle;
    } ptg_tbase_t;

    typedef struct packed {
        logic pri;
        logic sec;
        logic adc;
    } ptg_trig_t;

    typedef enum logic [1:0] {
        PTG_BUS_IDLE = 2'b00,
        PTG_BUS_DONE = 2'b01
    } ptg_bus_t;
endpackage : ptg_pkg

// ### bench/ptg_gen_props.sv
// Port checks for the trigger generator
`timescale 1ns/1ps
`include "ptg_cfg.svh"
module ptg_gen_props
    import ptg_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    input wire ptg_tbase_t tbase,
    input wire ptg_trig_t trig,
    input wire logic irq
);
    logic [15:0] pc_q;
    logic [15:0] sc_q;
    wire logic wr_now = avs_write && avs_waitrequest;
    // Compare shadows; a write lands on its first edge
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            pc_q <= 16'h0;
            sc_q <= 16'h0;
        end
        else if (wr_now && avs_address == `PTG_ADDR_PRI_CMP)
            pc_q <= avs_writedata[15:0];
        else if (wr_now && avs_address == `PTG_ADDR_SEC_CMP)
            sc_q <= avs_writedata[15:0];
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    a_reset_quiet: assert property (disable iff (1'b0) !nrst |=> trig == 3'h0 && !irq)
        else $error("outputs busy after reset");
    a_pri_pulse: assert property (trig.pri |=> !trig.pri)
        else $error("primary pulse too long");
    a_sec_pulse: assert property (trig.sec |=> !trig.sec)
        else $error("secondary pulse too long");
    a_pri_match: assert property (trig.pri |-> $past(tbase.count) == pc_q)
        else $error("primary pulse off its match");
    a_sec_match: assert property (trig.sec |-> $past(tbase.count) == sc_q)
        else $error("secondary pulse off its match");
    a_pri_to_adc: assert property (trig.pri |-> trig.adc)
        else $error("primary missing on adc");
    a_adc_cause: assert property (trig.adc |-> trig.pri || trig.sec)
        else $error("adc pulse without cause");
    a_bus_answer: assert property ($rose(avs_read || avs_write) |->
        avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus answer not in two cycles");
endmodule : ptg_gen_props

bind ptg_trigger_gen ptg_gen_props u_props (.clock, .nrst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_waitrequest, .tbase, .trig, .irq);

// ### bench/ptg_adc_sink.sv
// Model of the ADC trigger input: counts trigger pulses
`timescale 1ns/1ps
module ptg_adc_sink
    import ptg_pkg::*;
(
    input wire logic clock,
    input wire logic clr,
    input wire ptg_trig_t trig,
    output logic [7:0] n_pri,
    output logic [7:0] n_sec,
    output logic [7:0] n_adc
);
    // Counts high cycles, so a stretched pulse shows as extra
    always_ff @(posedge clock)
    begin
        if (clr)
        begin
            n_pri <= 8'h0;
            n_sec <= 8'h0;
            n_adc <= 8'h0;
        end
        else
        begin
            n_pri <= n_pri + 8'(trig.pri);
            n_sec <= n_sec + 8'(trig.sec);
            n_adc <= n_adc + 8'(trig.adc);
        end
    end
endmodule : ptg_adc_sink

// ### bench/tb.sv
// Bench for the trigger generator: mode table, irq and register tests
`timescale 1ns/1ps
`include "ptg_cfg.svh"
module tb;
    import ptg_pkg::*;
    localparam int P = 8;
    typedef struct {
        logic dual;
        logic [15:0] ctrl, pc, sc;
        logic ien;
        logic [7:0] np, ns, na;
        logic [2:0] st;
    } ptg_row_t;
    // Eight time-base cycles per row, period 8
    ptg_row_t rows [0:8] = '{
        '{1'h0, 16'h0000, 16'h3, 16'h5, 1'h1, 8'h8, 8'h8, 8'h8, 3'h7},
        '{1'h0, 16'h1a00, 16'h3, 16'h5, 1'h0, 8'h4, 8'h4, 8'h4, 3'h6},
        '{1'h1, 16'h0000, 16'h3, 16'h5, 1'h1, 8'h10, 8'h10, 8'h10, 3'h7},
        '{1'h1, 16'h0900, 16'h3, 16'h5, 1'h1, 8'h8, 8'h8, 8'h8, 3'h7},
        '{1'h1, 16'h0440, 16'h3, 16'h100, 1'h1, 8'h8, 8'h0, 8'h8, 3'h2},
        '{1'h1, 16'h0f00, 16'h3, 16'h5, 1'h1, 8'h10, 8'h10, 8'h10, 3'h7},
        '{1'h1, 16'h0200, 16'h0, 16'h5, 1'h1, 8'h8, 8'h8, 8'h8, 3'h7},
        '{1'h1, 16'h2080, 16'h3, 16'h5, 1'h1, 8'h5, 8'h5, 8'ha, 3'h7},
        '{1'h1, 16'hf000, 16'h3, 16'h5, 1'h1, 8'h1, 8'h1, 8'h1, 3'h7}};
    logic clock = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic avs_waitrequest, irq, module_enable = 1'b0, clr = 1'b1;
    ptg_tbase_t tbase = '{16'hffff, 16'h0008, 1'b0, 1'b0};
    ptg_trig_t trig;
    logic [7:0] n_pri, n_sec, n_adc;
    int err_total = 0, n_checks = 0, cyc = 0;

    always #10 clock = ~clock;

    ptg_trigger_gen DUT (.clock, .nrst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest,
        .tbase, .module_enable, .trig, .irq);
    ptg_adc_sink u_sink (.clock, .clr, .trig, .n_pri, .n_sec, .n_adc);

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Avalon access; holds until waitrequest is seen low
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task reset_dut;
        nrst <= 1'b0;
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
    endtask : reset_dut

    // Config only while the module is off; the count parks at ffff
    task setup(input ptg_row_t r);
        clr <= 1'b1;
        reset_dut;
        tbase.dual_cycle <= r.dual;
        bus(1'b1, `PTG_ADDR_CTRL, {16'h0, r.ctrl});
        bus(1'b1, `PTG_ADDR_PRI_CMP, {16'h0, r.pc});
        bus(1'b1, `PTG_ADDR_SEC_CMP, {16'h0, r.sc});
        bus(1'b1, `PTG_ADDR_CHAN, {10'h0, r.ien, 20'h0, r.dual});
        clr <= 1'b0;
    endtask : setup

    // Eight PWM cycles: edge 0..P, or dual 0..P..1
    task spin(input logic dual);
        int ph;
        module_enable <= 1'b1;
        for (int s = 0; s < (dual ? 16 * P : 8 * (P + 1)); s++)
        begin
            @(posedge clock);
            ph = dual ? s % (2 * P) : s % (P + 1);
            tbase.count <= 16'(ph <= P ? ph : 2 * P - ph);
            tbase.dir <= dual && ph > P;
        end
        @(posedge clock);
        tbase.count <= 16'hffff;
        module_enable <= 1'b0;
        repeat (3) @(posedge clock);
    endtask : spin

    task close_out;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : close_out

    // Ceiling well above the roughly 1400 cycles of the run
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            close_out;
        end
    end

    initial
    begin
        for (int i = 0; i < 9; i++)
        begin
            setup(rows[i]);
            spin(rows[i].dual);
            chk("pri", 32'(n_pri), 32'(rows[i].np));
            chk("sec", 32'(n_sec), 32'(rows[i].ns));
            chk("adc", 32'(n_adc), 32'(rows[i].na));
            chk("irq", 32'(irq), 32'h0);
            bus(1'b0, `PTG_ADDR_STATUS, 32'h0);
            chk("status", q, 32'(rows[i].st));
            $display("row %0d done", i);
        end
        setup(rows[0]);
        bus(1'b1, `PTG_ADDR_MASK, 32'h7);
        spin(1'b0);
        chk("irq_on", 32'(irq), 32'h1);
        bus(1'b0, `PTG_ADDR_STATUS, 32'h0);
        chk("st_read", q, 32'h7);
        repeat (2) @(posedge clock);
        chk("irq_off", 32'(irq), 32'h0);
        $display("irq test done");
        reset_dut;
        bus(1'b0, `PTG_ADDR_CTRL, 32'h0);
        chk("ctrl_rst", q, 32'h0);
        module_enable <= 1'b1;
        bus(1'b1, `PTG_ADDR_CTRL, 32'hffffffff);
        bus(1'b0, `PTG_ADDR_CTRL, 32'h0);
        chk("ctrl_run", q, 32'h0000f000);
        module_enable <= 1'b0;
        bus(1'b1, `PTG_ADDR_CTRL, 32'hffffffff);
        bus(1'b0, `PTG_ADDR_CTRL, 32'h0);
        chk("ctrl_rw", q, `PTG_CTRL_MASK);
        bus(1'b1, `PTG_ADDR_PRI_CMP, 32'hffffffff);
        bus(1'b0, `PTG_ADDR_PRI_CMP, 32'h0);
        chk("cmp_rw", q, `PTG_CMP_MASK);
        bus(1'b1, 4'hf, 32'hffffffff);
        bus(1'b0, 4'hf, 32'h0);
        chk("unmapped", q, 32'h0);
        $display("register test done");
        close_out;
    end
endmodule : tb
